// ---- core/rls_pkg.sv ----
// Purpose: Shared constants, types and helpers for the RS-485 link supervision block
// Assumes: 40 MHz control clock, 32-bit AHB-Lite register access
// Notes: All offsets, field positions, reset values and timing counts live here
package rls_pkg;

    // Clock and time base
    localparam int CLK_PERIOD_NS = 25;
    localparam int TICK_PERIOD_NS = 100000000; // 0.1 s timer resolution
    localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
    localparam logic [9:0] TICKS_PER_SEC = 10'h00a;
    localparam logic [9:0] ERR_TIMER_MAX = 10'h258; // 60.0 s in 0.1 s steps
    localparam logic [5:0] NORESP_MAX = 6'h3c; // 60 s

    // Register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_P1_CFG = 8'h04;
    localparam logic [7:0] REG_P1_TIM = 8'h08;
    localparam logic [7:0] REG_P2_CFG = 8'h0c;
    localparam logic [7:0] REG_P2_TIM = 8'h10;
    localparam logic [7:0] REG_STATUS = 8'h14;
    localparam logic [7:0] REG_MASK = 8'h18;
    localparam logic [7:0] REG_STATE = 8'h1c;

    // Field positions
    localparam int CTRL_LINK_SRC = 0;
    localparam int CFG_ADDR_LSB = 0;
    localparam int CFG_PROTO_LSB = 8;
    localparam int CFG_ACT_LSB = 10;
    localparam int TIM_ERR_LSB = 0;
    localparam int TIM_NR_LSB = 16;
    localparam int ST_ERR_LSB = 0;
    localparam int ST_ALARM_LSB = 2;
    localparam int ST_RECOV_LSB = 4;

    // Reset values
    localparam logic [0:0] CTRL_RST = 1'h0;
    localparam logic [11:0] CFG_RST = 12'h001; // Address 1, first protocol, trip at once
    localparam logic [9:0] TIM_ERR_RST = 10'h000;
    localparam logic [5:0] TIM_NR_RST = 6'h00;
    localparam logic [5:0] MASK_RST = 6'h00;

    // Protocols
    localparam logic [1:0] PROTO_MODBUS = 2'h0;
    localparam logic [1:0] PROTO_TOOL = 2'h1;
    localparam logic [1:0] PROTO_GENERAL = 2'h2;

    // Error actions
    localparam logic [1:0] ACT_TRIP = 2'h0;
    localparam logic [1:0] ACT_RUN_TIMER = 2'h1;
    localparam logic [1:0] ACT_RETRY = 2'h2;
    localparam logic [1:0] ACT_CONTINUE = 2'h3;

    // Station address ranges
    localparam logic [7:0] ADDR_MIN = 8'h01;
    localparam logic [7:0] MB_ADDR_MAX = 8'hf7;
    localparam logic [7:0] MB_BCAST = 8'h00;
    localparam logic [7:0] GP_ADDR_MAX = 8'h1f;
    localparam logic [7:0] GP_BCAST = 8'h63;
    localparam logic [7:0] TOOL_ADDR_MAX = 8'hff;

    // Supervision states
    typedef enum logic [2:0] {
        ST_WATCH = 3'b001,
        ST_GRACE = 3'b010,
        ST_ALARM = 3'b100
    } rls_state_e;

    // Own station address lies in the range of the active protocol
    function automatic logic rls_station_valid(input logic [1:0] proto, input logic [7:0] station);
        logic ok;
        ok = 1'b0;
        case (proto)
            PROTO_MODBUS: ok = (station >= ADDR_MIN) && (station <= MB_ADDR_MAX);
            PROTO_TOOL: ok = (station >= ADDR_MIN) && (station <= TOOL_ADDR_MAX);
            PROTO_GENERAL: ok = (station >= ADDR_MIN) && (station <= GP_ADDR_MAX);
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction

    // Received address is a broadcast of the active protocol
    function automatic logic rls_is_bcast(input logic [1:0] proto, input logic [7:0] rx);
        logic hit;
        hit = 1'b0;
        case (proto)
            PROTO_MODBUS: hit = (rx == MB_BCAST);
            PROTO_GENERAL: hit = (rx == GP_BCAST);
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction

endpackage

// ---- core/rls_port_if.sv ----
// Purpose: Carrier between the top and one per-port supervision engine
// Assumes: Single clock domain
// Notes: One instance per RS-485 port
`timescale 1ns/1ps
interface rls_port_if;
    logic enable;
    logic tick;
    logic err_event;
    logic good_frame;
    logic alarm_clr;
    logic [1:0] action;
    logic [9:0] err_timer;
    logic [5:0] noresp;
    logic alarm;
    logic err_seen;
    logic recovered;
    logic [2:0] state;

    modport sup (
        input enable, tick, err_event, good_frame, alarm_clr, action, err_timer, noresp,
        output alarm, err_seen, recovered, state
    );
    modport ctl (
        output enable, tick, err_event, good_frame, alarm_clr, action, err_timer, noresp,
        input alarm, err_seen, recovered, state
    );
endinterface // rls_port_if

// ---- core/rls_port_sup.sv ----
// Purpose: Error detection and error action engine for one RS-485 port
// Assumes: tick is a one-cycle pulse every 0.1 s
// Notes: Alarm holds until alarm_clr
`timescale 1ns/1ps
module rls_port_sup (
    input wire logic clk, // Control clock
    input wire logic rst_n, // Asynchronous reset, active low
    rls_port_if.sup port // Port control and status
);
    rls_pkg::rls_state_e state, next_state;
    logic [9:0] grace_cnt;
    logic [9:0] nr_cnt;

    // No-response limit in 0.1 s steps; zero means detection off
    wire [9:0] nr_limit = 10'({port.noresp, 3'b000}) + 10'({port.noresp, 1'b0});
    wire nr_on = port.enable && (port.noresp != 6'h00) && (state != rls_pkg::ST_ALARM);
    wire nr_expire = nr_on && (nr_cnt >= nr_limit);
    // Errors only count while running under link command
    wire err_hit = port.enable && (port.err_event || nr_expire) && (state != rls_pkg::ST_ALARM);
    wire grace_done = (grace_cnt >= port.err_timer);

    // Next state; each port runs its own copy so errors never cross ports
    always_comb begin
        next_state = state;
        case (state)
            rls_pkg::ST_WATCH: begin
                if (err_hit) begin
                    case (port.action)
                        rls_pkg::ACT_TRIP: next_state = rls_pkg::ST_ALARM;
                        rls_pkg::ACT_RUN_TIMER: next_state = rls_pkg::ST_GRACE;
                        rls_pkg::ACT_RETRY: next_state = rls_pkg::ST_GRACE;
                        default: next_state = rls_pkg::ST_WATCH;
                    endcase
                end
            end
            rls_pkg::ST_GRACE: begin
                if (!port.enable) begin
                    next_state = rls_pkg::ST_WATCH; // Drive stopped: nothing left to protect
                end else if (port.action == rls_pkg::ACT_RETRY && port.good_frame) begin
                    next_state = rls_pkg::ST_WATCH;
                end else if (grace_done) begin
                    next_state = rls_pkg::ST_ALARM;
                end
            end
            rls_pkg::ST_ALARM: begin
                if (port.alarm_clr) begin
                    next_state = rls_pkg::ST_WATCH;
                end
            end
            default: next_state = rls_pkg::ST_WATCH;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= rls_pkg::ST_WATCH;
        end else begin
            state <= next_state;
        end
    end

    // Grace timer restarts on entry, advances on the 0.1 s tick
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            grace_cnt <= 10'h000;
        end else if (state != rls_pkg::ST_GRACE) begin
            grace_cnt <= 10'h000;
        end else if (port.tick && !grace_done) begin
            grace_cnt <= grace_cnt + 10'h001;
        end
    end

    // Silence counter, cleared by any good frame addressed here
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            nr_cnt <= 10'h000;
        end else if (!nr_on || port.good_frame || nr_expire) begin
            nr_cnt <= 10'h000;
        end else if (port.tick) begin
            nr_cnt <= nr_cnt + 10'h001;
        end
    end

    assign port.alarm = (state == rls_pkg::ST_ALARM);
    assign port.err_seen = err_hit;
    assign port.recovered = (state == rls_pkg::ST_GRACE) && (next_state == rls_pkg::ST_WATCH) && port.enable;
    assign port.state = state;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_err_watch;
        (state == rls_pkg::ST_WATCH) && err_hit;
    endsequence

    property p_ignore_stopped;
        (state == rls_pkg::ST_WATCH) && !port.enable |=> (state == rls_pkg::ST_WATCH);
    endproperty
    a_ignore_stopped: assert property (p_ignore_stopped) else $error("error taken while not enabled");

    property p_trip_now;
        s_err_watch ##0 (port.action == rls_pkg::ACT_TRIP) |=> port.alarm;
    endproperty
    a_trip_now: assert property (p_trip_now) else $error("action 0 did not trip at once");

    property p_run_timer;
        s_err_watch ##0 (port.action == rls_pkg::ACT_RUN_TIMER) && (port.err_timer > 10'h001)
            |=> !port.alarm ##1 !port.alarm;
    endproperty
    a_run_timer: assert property (p_run_timer) else $error("action 1 alarmed before its timer");

    property p_no_recover_act1;
        (state == rls_pkg::ST_GRACE) && (port.action == rls_pkg::ACT_RUN_TIMER) && port.enable && !grace_done
            |=> (state == rls_pkg::ST_GRACE);
    endproperty
    a_no_recover_act1: assert property (p_no_recover_act1) else $error("action 1 left grace early");

    property p_retry_recover;
        (state == rls_pkg::ST_GRACE) && (port.action == rls_pkg::ACT_RETRY) && port.good_frame
            |=> (state == rls_pkg::ST_WATCH) && !port.alarm;
    endproperty
    a_retry_recover: assert property (p_retry_recover) else $error("action 2 did not recover");

    property p_continue;
        s_err_watch ##0 (port.action == rls_pkg::ACT_CONTINUE) |=> (state == rls_pkg::ST_WATCH);
    endproperty
    a_continue: assert property (p_continue) else $error("action 3 did not keep running");

    property p_grace_expire;
        (state == rls_pkg::ST_GRACE) && port.enable && grace_done && !port.good_frame |=> port.alarm;
    endproperty
    a_grace_expire: assert property (p_grace_expire) else $error("alarm missing at timer end");

    property p_nr_off;
        (port.noresp == 6'h00) |-> !nr_expire ##1 (nr_cnt == 10'h000);
    endproperty
    a_nr_off: assert property (p_nr_off) else $error("silence detection ran while disabled");

endmodule // rls_port_sup

// ---- core/rls_top.sv ----
// Purpose: Supervision of two RS-485 ports: station address check and error reaction
// Assumes: Frame events arrive synchronous to hclk from the two UART receivers
// Notes: Zero-wait AHB-Lite slave; interrupt from sticky status gated by mask
//
// Operation
// - Two ports, standard and optional, each with its own settings
// - Modbus addresses 1..247, broadcast 0; general protocol 1..31, broadcast 99
// - Tool protocol addresses 1..255 with no broadcast
// - Out-of-range own address: answer nothing, take only broadcasts
// - Address, parity, framing, protocol and silence faults are errors
// - Errors count only while running under link command source
// - Action 0 trips at once with port alarm
// - Action 1 runs for the timer, then alarms and stops
// - Action 2 retries for the timer; recovery continues, else alarm
// - Action 3 keeps running on errors
// - Keypad on standard port works whatever the port settings
// - Error timer per port 0.0 to 60.0 s
// - Silence timeout per port, 0 off, 1..60 s starts error handling
//
// The implementer's own choices: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
module rls_top #(
    parameter int TICK_CYCLES = rls_pkg::TICK_CYCLES, // Clock cycles per 0.1 s
    parameter int NUM_PORTS = 2 // Number of RS-485 ports
) (
    input wire logic hclk, // Control clock, 40 MHz
    input wire logic hresetn, // Asynchronous reset, active low
    input wire logic hsel, // AHB slave select
    input wire logic [7:0] haddr, // AHB byte address
    input wire logic [1:0] htrans, // AHB transfer type
    input wire logic hwrite, // AHB write
    input wire logic [2:0] hsize, // AHB size, word only
    input wire logic [31:0] hwdata, // AHB write data
    input wire logic hready, // AHB bus ready
    output logic hreadyout, // AHB slave ready
    output logic hresp, // AHB response, always OKAY
    output logic [31:0] hrdata, // AHB read data
    input wire logic drive_running, // Motor is running
    input wire logic alarm_reset, // Alarm reset pulse from the drive
    input wire logic keypad_attached, // Keypad sits on the standard port
    input wire logic [1:0] frame_done, // Frame received, per port
    input wire logic [1:0][7:0] rx_addr, // Address field of that frame
    input wire logic [1:0] addr_err, // Address fault
    input wire logic [1:0] parity_err, // Parity fault
    input wire logic [1:0] framing_err, // Framing fault
    input wire logic [1:0] proto_err, // Transmission protocol fault
    output logic [1:0] accept, // Frame is for this station
    output logic [1:0] respond, // Reply to this frame is allowed
    output logic [1:0] port_alarm, // Per-port communication alarm
    output logic trip, // Stop the motor with alarm
    output logic irq // Interrupt, active high level
);
    // Elaboration checks: the port logic is written for two ports and a 24-bit tick counter
    if (NUM_PORTS != 2) begin : g_bad_ports
        $error("rls_top serves exactly two ports");
    end
    if (TICK_CYCLES < 1 || TICK_CYCLES > 16777215) begin : g_bad_tick
        $error("TICK_CYCLES out of range");
    end

    logic [0:0] ctrl;
    logic [1:0][11:0] cfg;
    logic [1:0][9:0] tim_err;
    logic [1:0][5:0] tim_nr;
    logic [5:0] status;
    logic [5:0] mask;
    logic [23:0] tick_cnt;
    logic tick;
    logic dp_write;
    logic [7:0] dp_addr;
    logic [1:0] err_seen;
    logic [1:0] recovered;
    logic [1:0][2:0] pstate;
    logic [1:0] pstate_alarm_q;

    // Address phase qualifier; only NONSEQ/SEQ with bus ready start a transfer
    wire addr_phase = hsel && htrans[1] && hready;
    wire rd_start = addr_phase && !hwrite;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_write <= 1'b0;
            dp_addr <= 8'h00;
        end else if (hready) begin
            dp_write <= addr_phase && hwrite;
            dp_addr <= haddr;
        end
    end

    // Write strobes in the data phase
    wire wr_ctrl = dp_write && (dp_addr == rls_pkg::REG_CTRL);
    wire wr_cfg1 = dp_write && (dp_addr == rls_pkg::REG_P1_CFG);
    wire wr_tim1 = dp_write && (dp_addr == rls_pkg::REG_P1_TIM);
    wire wr_cfg2 = dp_write && (dp_addr == rls_pkg::REG_P2_CFG);
    wire wr_tim2 = dp_write && (dp_addr == rls_pkg::REG_P2_TIM);
    wire wr_status = dp_write && (dp_addr == rls_pkg::REG_STATUS);
    wire wr_mask = dp_write && (dp_addr == rls_pkg::REG_MASK);

    // Timer fields clamp at their top value so a wild write cannot stretch them
    wire [9:0] wd_err = hwdata[rls_pkg::TIM_ERR_LSB +: 10];
    wire [5:0] wd_nr = hwdata[rls_pkg::TIM_NR_LSB +: 6];
    wire [9:0] wd_err_cl = (wd_err > rls_pkg::ERR_TIMER_MAX) ? rls_pkg::ERR_TIMER_MAX : wd_err;
    wire [5:0] wd_nr_cl = (wd_nr > rls_pkg::NORESP_MAX) ? rls_pkg::NORESP_MAX : wd_nr;

    // Independent settings per port
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl <= rls_pkg::CTRL_RST;
            cfg <= {2{rls_pkg::CFG_RST}};
            tim_err <= {2{rls_pkg::TIM_ERR_RST}};
            tim_nr <= {2{rls_pkg::TIM_NR_RST}};
            mask <= rls_pkg::MASK_RST;
        end else begin
            if (wr_ctrl) ctrl <= hwdata[rls_pkg::CTRL_LINK_SRC +: 1];
            if (wr_cfg1) cfg[0] <= hwdata[11:0];
            if (wr_cfg2) cfg[1] <= hwdata[11:0];
            if (wr_tim1) begin
                tim_err[0] <= wd_err_cl;
                tim_nr[0] <= wd_nr_cl;
            end
            if (wr_tim2) begin
                tim_err[1] <= wd_err_cl;
                tim_nr[1] <= wd_nr_cl;
            end
            if (wr_mask) mask <= hwdata[5:0];
        end
    end

    // Sticky events; a new event in the clearing cycle survives the clear
    wire [5:0] events = {recovered, port_alarm & ~pstate_alarm_q, err_seen};
    wire [5:0] clr_bits = wr_status ? hwdata[5:0] : 6'h00;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status <= 6'h00;
            pstate_alarm_q <= 2'b00;
        end else begin
            status <= (status & ~clr_bits) | events;
            pstate_alarm_q <= port_alarm;
        end
    end

    assign irq = |(status & mask);

    // Read mux; unmapped offsets read zero
    wire [31:0] rd_state = {24'h000000, port_alarm[1], pstate[1], port_alarm[0], pstate[0]};
    wire [31:0] rd_tim1 = {10'h000, tim_nr[0], 6'h00, tim_err[0]};
    wire [31:0] rd_tim2 = {10'h000, tim_nr[1], 6'h00, tim_err[1]};
    wire [31:0] rd_mux =
        (haddr == rls_pkg::REG_CTRL) ? {31'h00000000, ctrl} :
        (haddr == rls_pkg::REG_P1_CFG) ? {20'h00000, cfg[0]} :
        (haddr == rls_pkg::REG_P1_TIM) ? rd_tim1 :
        (haddr == rls_pkg::REG_P2_CFG) ? {20'h00000, cfg[1]} :
        (haddr == rls_pkg::REG_P2_TIM) ? rd_tim2 :
        (haddr == rls_pkg::REG_STATUS) ? {26'h0000000, status} :
        (haddr == rls_pkg::REG_MASK) ? {26'h0000000, mask} :
        (haddr == rls_pkg::REG_STATE) ? rd_state : 32'h00000000;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (rd_start) begin
            hrdata <= rd_mux;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // 0.1 s time base shared by both ports
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tick_cnt <= 24'h000000;
            tick <= 1'b0;
        end else if (tick_cnt >= 24'(TICK_CYCLES - 1)) begin
            tick_cnt <= 24'h000000;
            tick <= 1'b1;
        end else begin
            tick_cnt <= tick_cnt + 24'h000001;
            tick <= 1'b0;
        end
    end

    // Errors only matter while running from link commands
    wire sup_enable = drive_running && ctrl[rls_pkg::CTRL_LINK_SRC];

    genvar i;
    generate
        for (i = 0; i < 2; i++) begin : g_port
            rls_port_if pif();
            wire [7:0] station = cfg[i][rls_pkg::CFG_ADDR_LSB +: 8];
            wire [1:0] proto = cfg[i][rls_pkg::CFG_PROTO_LSB +: 2];
            wire st_ok = rls_pkg::rls_station_valid(proto, station);
            wire bcast = rls_pkg::rls_is_bcast(proto, rx_addr[i]);
            wire unicast = st_ok && (rx_addr[i] == station);
            // Keypad traffic on the standard port bypasses the link settings
            wire kp = (i == 0) && keypad_attached;
            wire any_err = addr_err[i] | parity_err[i] | framing_err[i] | proto_err[i];

            assign accept[i] = kp || unicast || bcast;
            assign respond[i] = kp || unicast;

            assign pif.enable = sup_enable;
            assign pif.tick = tick;
            assign pif.err_event = frame_done[i] && any_err && !kp;
            assign pif.good_frame = frame_done[i] && !any_err && (unicast || bcast);
            assign pif.alarm_clr = alarm_reset;
            assign pif.action = cfg[i][rls_pkg::CFG_ACT_LSB +: 2];
            assign pif.err_timer = tim_err[i];
            assign pif.noresp = tim_nr[i];
            assign port_alarm[i] = pif.alarm;
            assign err_seen[i] = pif.err_seen;
            assign recovered[i] = pif.recovered;
            assign pstate[i] = pif.state;

            // One engine per port keeps timers and alarms apart
            rls_port_sup u_sup (
                .clk(hclk),
                .rst_n(hresetn),
                .port(pif.sup)
            );

            property p_bad_station;
                @(posedge hclk) disable iff (!hresetn) !st_ok && !kp |-> !respond[i];
            endproperty
            a_bad_station: assert property (p_bad_station) else $error("answer given with invalid station");

            property p_keypad;
                @(posedge hclk) disable iff (!hresetn) kp |-> accept[i] && respond[i];
            endproperty
            a_keypad: assert property (p_keypad) else $error("keypad frame refused");
        end
    endgenerate

    assign trip = |port_alarm;

    property p_irq_follow;
        @(posedge hclk) disable iff (!hresetn) (|(events & mask)) && !wr_mask |=> irq;
    endproperty
    a_irq_follow: assert property (p_irq_follow) else $error("masked-in event gave no interrupt");

    property p_read_status;
        @(posedge hclk) disable iff (!hresetn) rd_start && (haddr == rls_pkg::REG_STATUS)
            |=> (hrdata[5:0] == $past(status));
    endproperty
    a_read_status: assert property (p_read_status) else $error("status read returned wrong data");

endmodule // rls_top

// ---- tb/rls_host_model.sv ----
// Purpose: Host side frame source for the link supervision block
// Assumes: Frames reach the block already decoded by the receivers
// Notes: Strobe stands one cycle; idle address shows the inverse
`timescale 1ns/1ps
module rls_host_model (
    input wire logic clk, // Control clock
    output logic [1:0] frame_done, // End of frame strobe
    output logic [1:0][7:0] rx_addr, // Address field
    output logic [1:0] addr_err, // Address fault
    output logic [1:0] parity_err, // Parity fault
    output logic [1:0] framing_err, // Framing fault
    output logic [1:0] proto_err // Protocol fault
);
    // Quiet link at start
    initial begin
        frame_done = 2'h0;
        rx_addr = '0;
        {proto_err, framing_err, parity_err, addr_err} = 8'h00;
    end
    // Raise one frame end with its address and fault flags
    task automatic start(input int p, input logic [7:0] a, input logic [3:0] f);
        @(posedge clk);
        frame_done[p] <= 1'b1;
        rx_addr[p] <= a;
        {proto_err[p], framing_err[p], parity_err[p], addr_err[p]} <= f;
    endtask
    // Release: stale address is inverted so it cannot pass as valid
    task automatic stop;
        @(posedge clk);
        frame_done <= 2'h0;
        rx_addr <= ~rx_addr;
        {proto_err, framing_err, parity_err, addr_err} <= 8'h00;
    endtask
endmodule // rls_host_model

// ---- tb/rs485_link_supervision_tb.sv ----
// Purpose: Self-checking bench for the link supervision top
// Assumes: Tick shortened to 4 cycles
// Notes: Frames come from the host model
`timescale 1ns/1ps
module rs485_link_supervision_tb;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, drive_running, alarm_reset, keypad_attached;
    logic trip, irq;
    logic [7:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, rd;
    logic [1:0] frame_done, addr_err, parity_err, framing_err, proto_err, accept, respond, port_alarm;
    logic [1:0][7:0] rx_addr;
    int err_total = 0;
    int checked = 0;
    int cyc = 0;
    int i;
    assign hready = hreadyout;
    rls_top #(.TICK_CYCLES(4)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .drive_running(drive_running), .alarm_reset(alarm_reset),
        .keypad_attached(keypad_attached), .frame_done(frame_done), .rx_addr(rx_addr), .addr_err(addr_err),
        .parity_err(parity_err), .framing_err(framing_err), .proto_err(proto_err), .accept(accept),
        .respond(respond), .port_alarm(port_alarm), .trip(trip), .irq(irq));
    rls_host_model host (.clk(hclk), .frame_done(frame_done), .rx_addr(rx_addr), .addr_err(addr_err),
        .parity_err(parity_err), .framing_err(framing_err), .proto_err(proto_err));
    // Clock and a hang guard
    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            print_verdict;
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wait_clk(input int n);
        repeat (n) @(posedge hclk);
        #1;
    endtask
    // Single AHB-Lite transfer; read data lands in rd
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= a;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    // One frame; accept and respond judged while the strobe stands
    task automatic frm(input int p, input logic [7:0] a, input logic [3:0] f, input logic [1:0] ar);
        host.start(p, a, f);
        #1;
        chk({accept[p], respond[p]}, ar);
        host.stop();
    endtask
    task automatic t_regs;
        bus(0, rls_pkg::REG_P1_CFG, 0);
        chk({hreadyout, hresp, rd[29:0]}, 32'h80000001);
        bus(0, 8'h40, 0);
        chk(rd, 32'h0);
        bus(1, rls_pkg::REG_P2_TIM, 32'hffffffff);
        bus(0, rls_pkg::REG_P2_TIM, 0);
        chk(rd, 32'h003c0258);
        bus(1, rls_pkg::REG_P2_TIM, 0);
    endtask
    task automatic t_addr;
        frm(0, 8'h01, 0, 2'b11);
        frm(0, 8'h00, 0, 2'b10);
        frm(0, 8'hf8, 0, 2'b00);
        frm(1, 8'h01, 0, 2'b11);
        bus(1, rls_pkg::REG_P1_CFG, 32'h21f);
        frm(0, 8'h63, 0, 2'b10);
        frm(0, 8'h20, 0, 2'b00);
        bus(1, rls_pkg::REG_P1_CFG, 32'h1ff);
        frm(0, 8'hff, 0, 2'b11);
        frm(0, 8'h00, 0, 2'b00);
        bus(1, rls_pkg::REG_P1_CFG, 32'h0f8);
        frm(0, 8'hf8, 0, 2'b00);
        frm(0, 8'h00, 0, 2'b10);
        keypad_attached <= 1'b1;
        frm(0, 8'h05, 0, 2'b11);
        keypad_attached <= 1'b0;
    endtask
    task automatic t_errs;
        drive_running <= 1'b1;
        frm(0, 8'h01, 4'h1, 2'b00);
        bus(0, rls_pkg::REG_STATUS, 0);
        chk({port_alarm, rd[29:0]}, 32'h0);
        bus(1, rls_pkg::REG_CTRL, 1);
        bus(1, rls_pkg::REG_P1_CFG, 32'hc01);
        frm(0, 8'h01, 4'h2, 2'b11);
        bus(0, rls_pkg::REG_STATUS, 0);
        chk({port_alarm, rd[5:0]}, 8'h01);
        bus(1, rls_pkg::REG_P2_TIM, 5);
        bus(1, rls_pkg::REG_P2_CFG, 32'h801);
        frm(1, 8'h01, 4'h4, 2'b11);
        frm(1, 8'h01, 0, 2'b11);
        wait_clk(40);
        bus(0, rls_pkg::REG_STATUS, 0);
        chk({port_alarm, rd[5]}, 3'b001);
        bus(1, rls_pkg::REG_P2_CFG, 32'h401);
        frm(1, 8'h01, 4'h8, 2'b11);
        wait_clk(2);
        chk(port_alarm, 2'b00);
        for (i = 0; i < 60 && port_alarm[1] !== 1'b1; i++) wait_clk(1);
        chk({trip, port_alarm}, 3'b110);
    endtask
    task automatic t_trip;
        alarm_reset <= 1'b1;
        bus(1, rls_pkg::REG_STATUS, 32'h3f);
        alarm_reset <= 1'b0;
        bus(1, rls_pkg::REG_MASK, 32'h4);
        bus(1, rls_pkg::REG_P1_CFG, 32'h001);
        wait_clk(1);
        chk({irq, trip, port_alarm}, 4'b0000);
        frm(0, 8'h01, 4'h1, 2'b11);
        wait_clk(3);
        chk({irq, trip, port_alarm}, 4'b1101);
        bus(1, rls_pkg::REG_STATUS, 32'h3f);
        wait_clk(1);
        chk({irq, port_alarm}, 3'b001);
    endtask
    // Silence on port 2 with a 1 s timeout must trip it; port 1 keeps its own alarm
    task automatic t_silence;
        bus(1, rls_pkg::REG_P2_CFG, 32'h001);
        bus(1, rls_pkg::REG_P2_TIM, 32'h10000);
        wait_clk(30);
        chk(port_alarm, 2'b01);
        for (i = 0; i < 40 && port_alarm[1] !== 1'b1; i++) wait_clk(1);
        chk({trip, port_alarm}, 3'b111);
    endtask
    task automatic print_verdict;
        $display("Checks made %0d, mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Reset, then the scenarios in order
    initial begin
        {hsel, hwrite, haddr, htrans, hwdata} = '0;
        hsize = 3'h2;
        {drive_running, alarm_reset, keypad_attached} = 3'h0;
        hresetn = 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs;
        t_addr;
        t_errs;
        t_trip;
        t_silence;
        print_verdict;
    end
endmodule // rs485_link_supervision_tb
